// ==== asc_host_model.sv ====
module asc_host_model
(
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdata = 1'b0;
  end
  // clock stands still between frames; idle data shows the inverse of the last bit
  task automatic send(input logic [63:0] f, input int n);
    o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sdata = f[i];
      #6 o_sclk = 1'b1;
      #6 o_sclk = 1'b0;
    end
    #6 o_cs_n = 1'b1;
    o_sdata = ~o_sdata;
    #400;
  endtask
endmodule // asc_host_model

// ==== asc_pkg.sv ====
package asc_pkg;

  localparam int FRAME_W = 56;
  localparam int DAC_W = 8;
  localparam int STEP_W = 5;
  localparam int SYNC_W = 2;

  // step weights in dB, top bit to bottom bit
  localparam logic [4:0] STEP_DB_16 = 5'h10;
  localparam logic [4:0] STEP_DB_8 = 5'h08;
  localparam logic [4:0] STEP_DB_4 = 5'h04;
  localparam logic [4:0] STEP_DB_2 = 5'h02;
  localparam logic [4:0] STEP_DB_1 = 5'h01;

  localparam logic [7:0] DAC_RESET = 8'h00;
  localparam logic [4:0] STEP_RESET = 5'h00;
  localparam logic [55:0] FRAME_RESET = 56'h00000000000000;

  typedef logic [STEP_W-1:0] asc_step_t;
  typedef logic [DAC_W-1:0] asc_dac_t;

  // frame layout, most significant field first, as shifted
  typedef struct packed {
    asc_step_t path2_preset_state4;
    asc_step_t path2_preset_state3;
    asc_step_t path2_preset_state2;
    asc_step_t path2_preset_state1;
    asc_dac_t path2_dac_code;
    asc_step_t path1_preset_state4;
    asc_step_t path1_preset_state3;
    asc_step_t path1_preset_state2;
    asc_step_t path1_preset_state1;
    asc_dac_t path1_dac_code;
  } asc_frame_s;

  // parallel bus of one digital attenuator: value and enable
  typedef struct packed {
    asc_step_t value;
    logic oe;
  } asc_par_out_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SHIFT = 2'h1,
    ST_LOAD = 2'h3
  } asc_state_e;

endpackage

// ==== asc_serial_ctl.sv ====
// Overview of operation
// R1: frame bits 55..51 are path two preset word four, msb first.
// R2: frame bits 50..46 are path two preset word three, msb first.
// R3: frame bits 45..41 are path two preset word two, msb first.
// R4: frame bits 40..36 are path two preset word one, msb first.
// R5: frame bits 35..28 are the path two dac code, bit 35 msb.
// R6: frame bits 27..23 are path one preset word four, msb first.
// R7: path one preset word three is bits 22..18, msb first.
// R8: frame bits 17..13 are path one preset word two, msb first.
// R9: frame bits 12..8 are path one preset word one, msb first.
// R10: frame bits 7..0 are the path one dac code, bit 7 msb.
// R11: preset bits weigh 16, 8, 4, 2, 1 dB; attenuation is their sum.
// R12: analog attenuator driven by external voltage or its own dac.
// R13: digital attenuator set from serial contents or its parallel bus.
// R14: two static inputs choose analog and digital control sources.
// R15: host shifts 56 bits msb first, cs low, sampled on rising clock.
// R16: cs rising loads settings at once; settings hold during shifting. Here the load lands on the third ref clock edge after cs rises.
// R17: analog select 0 disables dacs; 1 enables dacs to control.
// R18: digital select 0 uses pins; 1 applies serial words, driven on pins.
// R19: longer frames keep the last 56 bits shifted.
module asc_serial_ctl
  import asc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdata,
  input wire logic i_analog_source_select,
  input wire logic i_digital_source_select,
  input wire asc_pkg::asc_step_t i_par_path1,
  input wire asc_pkg::asc_step_t i_par_path2,
  output asc_pkg::asc_step_t o_par_path1,
  output logic o_par_path1_oe,
  output asc_pkg::asc_step_t o_par_path2,
  output logic o_par_path2_oe,
  output asc_pkg::asc_dac_t o_path1_dac_code,
  output asc_pkg::asc_dac_t o_path2_dac_code,
  output logic o_dac_enable,
  output asc_pkg::asc_step_t o_path1_step_en,
  output asc_pkg::asc_step_t o_path2_step_en,
  output asc_pkg::asc_frame_s o_settings
);
  import asc_pkg::*;

  // one weight of a preset word: the weight itself when its bit is set
  function automatic asc_step_t step_hit(input asc_step_t w, input asc_step_t weight);
    asc_step_t hit;
    hit = STEP_RESET;
    if ((w & weight) != STEP_RESET)
      hit = weight;
    return hit;
  endfunction

  function automatic asc_step_t step_enables(input asc_step_t w);
    asc_step_t en;
    en = STEP_RESET;
    en = en | step_hit(w, STEP_DB_16); // R11
    en = en | step_hit(w, STEP_DB_8); // R11
    en = en | step_hit(w, STEP_DB_4); // R11
    en = en | step_hit(w, STEP_DB_2); // R11
    en = en | step_hit(w, STEP_DB_1); // R11
    return en;
  endfunction

  // serial preset or the synchronised parallel bus, per digital select
  function automatic asc_step_t pick_step(
    input logic serial,
    input asc_step_t preset,
    input asc_step_t pins
  );
    asc_step_t chosen;
    chosen = pins;
    if (serial)
      chosen = preset; // R13 R18
    return chosen;
  endfunction

  // a disabled dac reads zero so a stale code never reaches the converter
  function automatic asc_dac_t gate_dac(
    input logic enabled,
    input asc_dac_t code
  );
    asc_dac_t gated;
    gated = DAC_RESET;
    if (enabled)
      gated = code; // R12 R17
    return gated;
  endfunction

  // last stage of a two-flop chain; nothing else reads the first stage
  function automatic logic sync_tail(input logic [SYNC_W-1:0] chain);
    return chain[SYNC_W-1];
  endfunction

  // next value of a two-flop chain
  function automatic logic [SYNC_W-1:0] sync_shift(
    input logic [SYNC_W-1:0] chain,
    input logic pin
  );
    return {chain[SYNC_W-2:0], pin};
  endfunction

  // serial clock domain: plain shift register, old bits fall off the top
  logic [FRAME_W-1:0] shift_reg;
  logic [FRAME_W-1:0] shift_next;

  assign shift_next = {shift_reg[FRAME_W-2:0], i_sdata}; // R15 R19

  always_ff @(posedge i_sclk or posedge i_rst)
  begin
    if (i_rst)
      shift_reg <= FRAME_RESET;
    else if (!i_cs_n)
      shift_reg <= shift_next; // R15
  end

  // reference domain synchronisers, one short process per chain
  logic [SYNC_W-1:0] cs_sync_reg;
  logic [SYNC_W-1:0] cs_sync_next;
  logic [SYNC_W-1:0] asel_sync_reg;
  logic [SYNC_W-1:0] asel_sync_next;
  logic [SYNC_W-1:0] dsel_sync_reg;
  logic [SYNC_W-1:0] dsel_sync_next;
  asc_step_t par1_meta_reg;
  asc_step_t par1_sync_reg;
  asc_step_t par2_meta_reg;
  asc_step_t par2_sync_reg;

  assign cs_sync_next = sync_shift(cs_sync_reg, i_cs_n);
  assign asel_sync_next = sync_shift(asel_sync_reg, i_analog_source_select); // R14
  assign dsel_sync_next = sync_shift(dsel_sync_reg, i_digital_source_select); // R14

  // cs idles high, so the chain resets high and no false frame follows reset
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cs_sync_reg <= '1;
    end
    else
    begin
      cs_sync_reg <= cs_sync_next;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      asel_sync_reg <= '0;
    end
    else
    begin
      asel_sync_reg <= asel_sync_next;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dsel_sync_reg <= '0;
    end
    else
    begin
      dsel_sync_reg <= dsel_sync_next;
    end
  end

  // per-bit sync only: a skewed bus change may show one mixed word for a cycle
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      par1_meta_reg <= STEP_RESET;
      par1_sync_reg <= STEP_RESET;
    end
    else
    begin
      par1_meta_reg <= i_par_path1; // R13
      par1_sync_reg <= par1_meta_reg;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      par2_meta_reg <= STEP_RESET;
      par2_sync_reg <= STEP_RESET;
    end
    else
    begin
      par2_meta_reg <= i_par_path2; // R13
      par2_sync_reg <= par2_meta_reg;
    end
  end

  logic cs_high;
  logic analog_sel;
  logic digital_sel;

  assign cs_high = sync_tail(cs_sync_reg);
  assign analog_sel = sync_tail(asel_sync_reg); // R14
  assign digital_sel = sync_tail(dsel_sync_reg); // R14

  // frame tracker: load only once cs is seen high after a low stretch
  asc_state_e state_reg;
  asc_state_e state_next;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (!cs_high) state_next = ST_SHIFT;
      ST_SHIFT: if (cs_high) state_next = ST_LOAD;
      ST_LOAD: state_next = cs_high ? ST_IDLE : ST_SHIFT;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // shift register is quiet here: cs is high so the serial clock is ignored
  logic load_now;
  asc_frame_s frame_in;
  asc_frame_s settings_reg;
  asc_frame_s settings_next;

  assign load_now = (state_reg == ST_SHIFT) && cs_high; // R16
  assign frame_in = asc_frame_s'(shift_reg); // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10
  // settings move only on a load, never while a frame is open
  assign settings_next = load_now ? frame_in : settings_reg; // R16

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      settings_reg <= asc_frame_s'(FRAME_RESET);
    else
      settings_reg <= settings_next; // R16
  end

  // source selection
  asc_step_t serial1_word;
  asc_step_t serial2_word;
  asc_step_t dig1_next;
  asc_step_t dig2_next;

  // without preset select pins the first preset word of each path applies
  assign serial1_word = settings_reg.path1_preset_state1; // R9
  assign serial2_word = settings_reg.path2_preset_state1; // R4
  assign dig1_next = pick_step(digital_sel, serial1_word, par1_sync_reg); // R13
  assign dig2_next = pick_step(digital_sel, serial2_word, par2_sync_reg); // R13

  asc_par_out_s par1_reg;
  asc_par_out_s par1_next;
  asc_par_out_s par2_reg;
  asc_par_out_s par2_next;
  asc_step_t step1_reg;
  asc_step_t step1_next;
  asc_step_t step2_reg;
  asc_step_t step2_next;
  asc_dac_t dac1_reg;
  asc_dac_t dac1_next;
  asc_dac_t dac2_reg;
  asc_dac_t dac2_next;
  logic dac_en_reg;
  logic dac_en_next;

  // pin value is a don't-care while released, so it always carries the serial word
  assign par1_next = '{value: serial1_word, oe: digital_sel}; // R18
  assign par2_next = '{value: serial2_word, oe: digital_sel}; // R18
  assign step1_next = step_enables(dig1_next); // R11
  assign step2_next = step_enables(dig2_next); // R11
  assign dac1_next = gate_dac(analog_sel, settings_reg.path1_dac_code); // R12
  assign dac2_next = gate_dac(analog_sel, settings_reg.path2_dac_code); // R12
  assign dac_en_next = analog_sel; // R17

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      par1_reg <= '0;
    end
    else
    begin
      par1_reg <= par1_next; // R18
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      par2_reg <= '0;
    end
    else
    begin
      par2_reg <= par2_next; // R18
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      step1_reg <= STEP_RESET;
    end
    else
    begin
      step1_reg <= step1_next; // R13
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      step2_reg <= STEP_RESET;
    end
    else
    begin
      step2_reg <= step2_next; // R13
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dac1_reg <= DAC_RESET;
    end
    else
    begin
      dac1_reg <= dac1_next; // R12
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dac2_reg <= DAC_RESET;
    end
    else
    begin
      dac2_reg <= dac2_next; // R12
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dac_en_reg <= '0;
    end
    else
    begin
      dac_en_reg <= dac_en_next; // R17
    end
  end

  assign o_par_path1 = par1_reg.value;
  assign o_par_path1_oe = par1_reg.oe;
  assign o_par_path2 = par2_reg.value;
  assign o_par_path2_oe = par2_reg.oe;
  assign o_path1_dac_code = dac1_reg;
  assign o_path2_dac_code = dac2_reg;
  assign o_dac_enable = dac_en_reg;
  assign o_path1_step_en = step1_reg;
  assign o_path2_step_en = step2_reg;
  assign o_settings = settings_reg;

endmodule // asc_serial_ctl

// ==== asc_serial_ctl_asserts.sv ====
module asc_serial_ctl_asserts
  import asc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_analog_source_select,
  input wire logic i_digital_source_select,
  input wire asc_pkg::asc_step_t i_par_path1,
  input wire asc_pkg::asc_step_t o_par_path1,
  input wire logic o_par_path1_oe,
  input wire asc_pkg::asc_dac_t o_path1_dac_code,
  input wire logic o_dac_enable,
  input wire asc_pkg::asc_step_t o_path1_step_en,
  input wire asc_pkg::asc_frame_s o_settings
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // load waits two sync edges, so nothing may move right after cs rises
  chk_load_wait: assert property ($rose(i_cs_n) |=> $stable(o_settings) [*2])
    else $error("early load");
  chk_set_hold: assert property (!i_cs_n |=> $stable(o_settings)) else $error("moved");
  chk_dac_en: assert property ($stable(i_analog_source_select) [*4]
    |-> o_dac_enable == i_analog_source_select) else $error("dac enable");
  chk_dac_off: assert property (!i_analog_source_select [*5]
    |-> o_path1_dac_code == 8'h00) else $error("dac off");
  chk_dac_on: assert property ((i_analog_source_select && $stable(o_settings)) [*5]
    |-> o_path1_dac_code == o_settings.path1_dac_code) else $error("dac code");
  chk_pin_oe: assert property ($stable(i_digital_source_select) [*5]
    |-> o_par_path1_oe == i_digital_source_select) else $error("oe");
  chk_serial_step: assert property ((i_digital_source_select && $stable(o_settings)) [*5]
    |-> o_path1_step_en == o_settings.path1_preset_state1 && o_par_path1 == o_path1_step_en)
    else $error("serial step");
  chk_par_step: assert property ((!i_digital_source_select && $stable(i_par_path1)) [*5]
    |-> o_path1_step_en == i_par_path1) else $error("par step");
  cover property ($rose(i_cs_n));
  cover property (!i_analog_source_select [*5]);
  cover property (!i_digital_source_select && o_path1_step_en != 5'h00);
endmodule // asc_serial_ctl_asserts
bind asc_serial_ctl asc_serial_ctl_asserts asc_serial_ctl_asserts_i (
  .i_ref_clk(i_ref_clk),
  .i_rst(i_rst),
  .i_cs_n(i_cs_n),
  .i_analog_source_select(i_analog_source_select),
  .i_digital_source_select(i_digital_source_select),
  .i_par_path1(i_par_path1),
  .o_par_path1(o_par_path1),
  .o_par_path1_oe(o_par_path1_oe),
  .o_path1_dac_code(o_path1_dac_code),
  .o_dac_enable(o_dac_enable),
  .o_path1_step_en(o_path1_step_en),
  .o_settings(o_settings)
);

// ==== asc_serial_ctl_test.sv ====
module asc_serial_ctl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import asc_pkg::*;
  logic i_ref_clk, i_rst, i_sclk, i_cs_n, i_sdata, i_analog_source_select, i_digital_source_select;
  asc_step_t i_par_path1, i_par_path2, o_par_path1, o_par_path2, o_path1_step_en, o_path2_step_en;
  asc_dac_t o_path1_dac_code, o_path2_dac_code;
  logic o_par_path1_oe, o_par_path2_oe, o_dac_enable;
  asc_frame_s o_settings, e;
  int n_mismatch = 0;
  int n_tests = 0;
  asc_serial_ctl asc_serial_ctl_i (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_sdata(i_sdata),
    .i_analog_source_select(i_analog_source_select),
    .i_digital_source_select(i_digital_source_select),
    .i_par_path1(i_par_path1),
    .i_par_path2(i_par_path2),
    .o_par_path1(o_par_path1),
    .o_par_path1_oe(o_par_path1_oe),
    .o_par_path2(o_par_path2),
    .o_par_path2_oe(o_par_path2_oe),
    .o_path1_dac_code(o_path1_dac_code),
    .o_path2_dac_code(o_path2_dac_code),
    .o_dac_enable(o_dac_enable),
    .o_path1_step_en(o_path1_step_en),
    .o_path2_step_en(o_path2_step_en),
    .o_settings(o_settings)
  );
  asc_host_model asc_host_model_i (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdata(i_sdata));
  task automatic chk(input string nm, input logic [55:0] ex, input logic [55:0] got);
    n_tests++;
    if (got !== ex)
    begin
      $display("BAD %s exp %h got %h", nm, ex, got);
      n_mismatch++;
    end
  endtask
  task automatic t_serial();
    e = '{5'h10, 5'h08, 5'h04, 5'h02, 8'ha5, 5'h01, 5'h11, 5'h1f, 5'h16, 8'h3c};
    i_analog_source_select = 1'b1;
    i_digital_source_select = 1'b1;
    asc_host_model_i.send({8'h00, e}, 56);
    @(negedge i_ref_clk);
    chk("settings", e, o_settings);
    chk("dac2", e.path2_dac_code, o_path2_dac_code);
    chk("step2", e.path2_preset_state1, o_path2_step_en);
    chk("pin2", {e.path2_preset_state1, 1'b1}, {o_par_path2, o_par_path2_oe});
    chk("path1", {e.path1_dac_code, e.path1_preset_state1, e.path1_preset_state1, 2'h3},
      {o_path1_dac_code, o_path1_step_en, o_par_path1, o_par_path1_oe, o_dac_enable});
  endtask
  task automatic t_long();
    asc_host_model_i.send({8'h09, ~e}, 60);
    @(negedge i_ref_clk);
    chk("long", ~e, o_settings);
    chk("long1", {~e.path1_dac_code}, o_path1_dac_code);
  endtask
  task automatic t_modes();
    i_analog_source_select = 1'b0;
    i_digital_source_select = 1'b0;
    i_par_path1 = STEP_DB_16 | STEP_DB_2 | STEP_DB_1;
    i_par_path2 = 5'h0c;
    repeat (5) @(negedge i_ref_clk);
    chk("dacs", 17'h0, {o_path1_dac_code, o_path2_dac_code, o_dac_enable});
    chk("step1", 5'h13, o_path1_step_en);
    chk("step2p", 6'h18, {o_path2_step_en, o_par_path2_oe});
    chk("kept", ~e, o_settings);
    chk("pin1p", {~e.path1_preset_state1, 1'b0}, {o_par_path1, o_par_path1_oe});
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    i_rst = 1'b1;
    i_analog_source_select = 1'b0;
    i_digital_source_select = 1'b0;
    i_par_path1 = 5'h00;
    i_par_path2 = 5'h00;
    repeat (6) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    t_serial();
    t_long();
    t_modes();
    print_verdict();
  end
endmodule // asc_serial_ctl_test
